// ---- design/rlx_map.svh ----
`ifndef RLX_MAP_SVH
`define RLX_MAP_SVH

// =====================================================================
// Command and log addresses
`define CMD_READ_LOG_EXT 8'h2f
`define LOG_DIR 8'h00
`define LOG_COMP_ERR 8'h03
`define LOG_SELFTEST 8'h06
`define LOG_EXT_SELFTEST 8'h07
`define LOG_POWER 8'h08
`define LOG_NCQ_ERR 8'h10
`define LOG_PHY 8'h11
`define LOG_QMGMT 8'h12
`define LOG_REBUILD 8'h15
`define LOG_WSTREAM 8'h21
`define LOG_RSTREAM 8'h22
`define LOG_IDENT 8'h30
`define LOG_VENDOR_FIRST 8'h80
`define LOG_VENDOR_LAST 8'h9f

// =====================================================================
// Log lengths in sectors
`define SZ_ONE 16'h0001
`define SZ_VENDOR 16'h0010
`define SZ_NONE 16'h0000

// =====================================================================
// Feature enable bit positions
`define FE_SMART_ERR 0
`define FE_SELFTEST 1
`define FE_EPC 2
`define FE_NCQ 3
`define FE_PHY 4
`define FE_QMGMT 5
`define FE_STREAM 6
`define FE_SMART 7
`define FE_REBUILD 8

// =====================================================================
// Task file register addresses on the link
`define TF_DATA 3'h0
`define TF_ERROR 3'h1
`define TF_COUNT 3'h2
`define TF_SECNUM 3'h3
`define TF_CYLLOW 3'h4
`define TF_CYLHIGH 3'h5
`define TF_DEVHEAD 3'h6
`define TF_CMD 3'h7

// =====================================================================
// Status and error values
`define ST_BUSY 8'hd0
`define ST_DRQ 8'h58
`define ST_DONE 8'h50
`define ST_ABORT 8'h51
`define ERR_ABRT 8'h04
`define ST_ERR_BIT 0
`define ST_DRQ_BIT 3
`define DH_DEV_BIT 4
`define DH_FIXED 8'ha0
`define WORD_LAST 8'hff

// =====================================================================
// Controller register word addresses and fields
`define CR_CTRL 3'h0
`define CR_XFER 3'h1
`define CR_STATUS 3'h2
`define CR_DATA 3'h3
`define CR_IRQ_ST 3'h4
`define CR_IRQ_MASK 3'h5
`define CTRL_DEV_BIT 16
`define IRQ_BLOCK 0
`define IRQ_DONE 1
`define IRQ_ABORT 2

`endif

// ---- design/rlx_pkg.sv ----
package rlx_pkg;

  typedef logic [8:0] feat_type;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_FETCH = 3'b010,
    D_XFER = 3'b100
  } dev_state_type;

  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001,
    H_TF = 7'b0000010,
    H_WAIT = 7'b0000100,
    H_STAT = 7'b0001000,
    H_ERRW = 7'b0010000,
    H_DATA = 7'b0100000,
    H_DWT = 7'b1000000
  } host_state_type;

endpackage : rlx_pkg

// ---- design/ata_link_if.sv ----
`timescale 1ns/1ps
interface ata_link_if;
  logic wr;
  logic rd;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic intrq;
  modport device(input wr, input rd, input addr, input wdata, output rdata, output intrq);
  modport host(output wr, output rd, output addr, output wdata, input rdata, input intrq);
endinterface : ata_link_if

// ---- design/log_reader_device.sv ----
`timescale 1ns/1ps
`include "rlx_map.svh"
module log_reader_device
#(
  parameter logic DEV_SELECT = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  ata_link_if.device link,
  input wire rlx_pkg::feat_type feat_en,
  output logic [7:0] log_sel,
  output logic [15:0] log_sector,
  output logic [7:0] log_word,
  input wire logic [15:0] log_data,
  output logic busy
);
  import rlx_pkg::*;

  typedef struct packed {
    dev_state_type st;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sec_cur;
    logic [7:0] cyl_cur;
    logic [7:0] cyl_prev;
    logic [7:0] devhead;
    logic [7:0] status;
    logic [7:0] error;
    logic intrq;
    logic [7:0] log_num;
    logic [15:0] sector;
    logic [15:0] left;
    logic [7:0] word;
    logic [15:0] dword;
    logic [15:0] rdata;
  } dev_regs_type;

  dev_regs_type s;
  dev_regs_type n;
  logic [15:0] size;
  logic [15:0] count;
  logic [15:0] start;
  logic [16:0] span;
  logic cmd_hit;

  // =====================================================================
  // Log decode
  // A length of zero means the log is unknown, reserved or switched off.
  function automatic logic [15:0] log_size(input logic [7:0] a, input feat_type en);
    logic [15:0] r;
    r = `SZ_NONE;
    case (a)
      `LOG_DIR: r = `SZ_ONE;
      `LOG_COMP_ERR: r = en[`FE_SMART_ERR] ? `SZ_ONE : `SZ_NONE;
      `LOG_SELFTEST: r = `SZ_NONE;
      `LOG_EXT_SELFTEST: r = en[`FE_SELFTEST] ? `SZ_ONE : `SZ_NONE;
      `LOG_POWER: r = en[`FE_EPC] ? `SZ_ONE : `SZ_NONE;
      `LOG_NCQ_ERR: r = en[`FE_NCQ] ? `SZ_ONE : `SZ_NONE;
      `LOG_PHY: r = en[`FE_PHY] ? `SZ_ONE : `SZ_NONE;
      `LOG_QMGMT: r = en[`FE_QMGMT] ? `SZ_ONE : `SZ_NONE;
      `LOG_REBUILD: r = en[`FE_REBUILD] ? `SZ_ONE : `SZ_NONE;
      `LOG_WSTREAM: r = en[`FE_STREAM] ? `SZ_ONE : `SZ_NONE;
      `LOG_RSTREAM: r = en[`FE_STREAM] ? `SZ_ONE : `SZ_NONE;
      `LOG_IDENT: r = `SZ_ONE;
      default:
      begin
        if (a >= `LOG_VENDOR_FIRST && a <= `LOG_VENDOR_LAST && en[`FE_SMART])
        begin
          r = `SZ_VENDOR;
        end
      end
    endcase
    return r;
  endfunction : log_size

  // =====================================================================
  // Command check
  assign count = {s.cnt_prev, s.cnt_cur};
  assign start = {s.cyl_prev, s.cyl_cur};
  assign size = log_size(s.sec_cur, feat_en);
  assign span = {1'b0, start} + {1'b0, count};
  // Commands for the other device on the cable are left alone.
  assign cmd_hit = link.wr && link.addr == `TF_CMD && s.st == D_IDLE
    && s.devhead[`DH_DEV_BIT] == DEV_SELECT;

  // =====================================================================
  // Next state
  always_comb
  begin
    n = s;
    if (link.wr && s.st == D_IDLE)
    begin
      case (link.addr)
        `TF_COUNT:
        begin
          n.cnt_prev = s.cnt_cur;
          n.cnt_cur = link.wdata[7:0];
        end
        `TF_SECNUM: n.sec_cur = link.wdata[7:0];
        `TF_CYLLOW:
        begin
          n.cyl_prev = s.cyl_cur;
          n.cyl_cur = link.wdata[7:0];
        end
        `TF_DEVHEAD: n.devhead = link.wdata[7:0];
        default:
        begin
        end
      endcase
    end
    if (cmd_hit)
    begin
      // Range is checked against the whole request so no block is sent
      // past the end of the log.
      if (link.wdata[7:0] == `CMD_READ_LOG_EXT && size != `SZ_NONE && count != 16'h0000
        && span <= {1'b0, size})
      begin
        n.st = D_FETCH;
        n.log_num = s.sec_cur;
        n.sector = start;
        n.left = count;
        n.word = 8'h00;
        n.status = `ST_BUSY;
        n.error = 8'h00;
      end
      else
      begin
        n.status = `ST_ABORT;
        n.error = `ERR_ABRT;
        n.intrq = 1'b1;
      end
    end
    if (link.rd)
    begin
      n.rdata = 16'h0000;
      case (link.addr)
        `TF_CMD:
        begin
          n.rdata = {8'h00, s.status};
          n.intrq = 1'b0;
        end
        `TF_ERROR: n.rdata = {8'h00, s.error};
        default:
        begin
        end
      endcase
    end
    case (s.st)
      D_IDLE:
      begin
      end
      D_FETCH:
      begin
        n.dword = log_data;
        n.st = D_XFER;
        n.status = `ST_DRQ;
        if (s.word == 8'h00)
        begin
          n.intrq = 1'b1;
        end
      end
      D_XFER:
      begin
        if (link.rd && link.addr == `TF_DATA)
        begin
          n.rdata = s.dword;
          n.st = D_FETCH;
          n.word = s.word + 8'h01;
          if (s.word == `WORD_LAST)
          begin
            n.sector = s.sector + 16'h0001;
            n.left = s.left - 16'h0001;
            n.status = `ST_BUSY;
            if (s.left == 16'h0001)
            begin
              n.st = D_IDLE;
              n.status = `ST_DONE;
            end
          end
        end
      end
      default:
      begin
        n.st = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= D_IDLE;
      s.status <= `ST_DONE;
    end
    else
    begin
      s <= n;
    end
  end

  // =====================================================================
  // Outputs
  assign link.rdata = s.rdata;
  assign link.intrq = s.intrq;
  assign log_sel = s.log_num;
  assign log_sector = s.sector;
  assign log_word = s.word;
  assign busy = s.st != D_IDLE;

endmodule : log_reader_device

// ---- design/log_reader_host.sv ----
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "rlx_map.svh"
module log_reader_host
(
  input wire logic sys_clk,
  input wire logic rst,
  ata_link_if.host link,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  import rlx_pkg::*;

  typedef struct packed {
    host_state_type st;
    logic [2:0] idx;
    logic pend;
    logic lwr;
    logic lrd;
    logic [2:0] laddr;
    logic [7:0] lwdata;
    logic [7:0] log_num;
    logic dev;
    logic [15:0] count;
    logic [15:0] start;
    logic [15:0] left;
    logic [7:0] wcnt;
    logic [15:0] word;
    logic wvalid;
    logic [7:0] ata_st;
    logic [7:0] ata_err;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } host_regs_type;

  host_regs_type s;
  host_regs_type n;

  // =====================================================================
  // Task file load order: previous bytes go first so they shift behind.
  function automatic logic [10:0] tf_write(input logic [2:0] i, input host_regs_type r);
    logic [10:0] w;
    w = {`TF_CMD, `CMD_READ_LOG_EXT};
    case (i)
      3'h0: w = {`TF_COUNT, r.count[15:8]};
      3'h1: w = {`TF_COUNT, r.count[7:0]};
      3'h2: w = {`TF_SECNUM, r.log_num};
      3'h3: w = {`TF_CYLLOW, r.start[15:8]};
      3'h4: w = {`TF_CYLLOW, r.start[7:0]};
      3'h5: w = {`TF_DEVHEAD, `DH_FIXED | {3'h0, r.dev, 4'h0}};
      default:
      begin
      end
    endcase
    return w;
  endfunction : tf_write

  // =====================================================================
  // Next state
  always_comb
  begin
    logic [2:0] ev;
    logic [10:0] tw;
    ev = 3'h0;
    tw = tf_write(s.idx, s);
    n = s;
    n.lwr = 1'b0;
    n.lrd = 1'b0;
    n.ack = (avs_read | avs_write) & ~s.ack;
    if (avs_read && !s.ack)
    begin
      case (avs_address)
        `CR_XFER: n.rdata = {s.start, s.count};
        `CR_STATUS: n.rdata = {8'h00, s.ata_err, s.ata_st, 6'h00, s.wvalid, s.st != H_IDLE};
        `CR_DATA: n.rdata = {16'h0000, s.word};
        `CR_IRQ_ST: n.rdata = {29'h0, s.irq_st};
        `CR_IRQ_MASK: n.rdata = {29'h0, s.irq_mask};
        default: n.rdata = 32'h0;
      endcase
    end
    if (avs_read && s.ack)
    begin
      if (avs_address == `CR_DATA)
      begin
        n.wvalid = 1'b0;
      end
      if (avs_address == `CR_IRQ_ST)
      begin
        n.irq_st = 3'h0;
      end
    end
    if (avs_write && s.ack)
    begin
      case (avs_address)
        `CR_CTRL:
        begin
          if (avs_writedata[0] && s.st == H_IDLE)
          begin
            n.log_num = avs_writedata[15:8];
            n.dev = avs_writedata[`CTRL_DEV_BIT];
            n.left = s.count;
            n.wcnt = 8'h00;
            n.idx = 3'h0;
            n.st = H_TF;
          end
        end
        `CR_XFER:
        begin
          n.count = avs_writedata[15:0];
          n.start = avs_writedata[31:16];
        end
        `CR_IRQ_MASK: n.irq_mask = avs_writedata[2:0];
        default:
        begin
        end
      endcase
    end
    case (s.st)
      H_IDLE:
      begin
      end
      H_TF:
      begin
        n.lwr = 1'b1;
        n.laddr = tw[10:8];
        n.lwdata = tw[7:0];
        n.idx = s.idx + 3'h1;
        if (s.idx == 3'h6)
        begin
          n.st = H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (link.intrq)
        begin
          n.lrd = 1'b1;
          n.laddr = `TF_CMD;
          n.pend = 1'b1;
          n.st = H_STAT;
        end
      end
      H_STAT:
      begin
        n.pend = 1'b0;
        if (!s.pend)
        begin
          n.ata_st = link.rdata[7:0];
          n.st = link.rdata[`ST_DRQ_BIT] ? H_DATA : H_WAIT;
          if (link.rdata[`ST_ERR_BIT])
          begin
            n.lrd = 1'b1;
            n.laddr = `TF_ERROR;
            n.pend = 1'b1;
            n.st = H_ERRW;
          end
        end
      end
      H_ERRW:
      begin
        n.pend = 1'b0;
        if (!s.pend)
        begin
          n.ata_err = link.rdata[7:0];
          ev[`IRQ_ABORT] = 1'b1;
          n.st = H_IDLE;
        end
      end
      H_DATA:
      begin
        // Each word waits for software, so the device is never rushed.
        if (!s.wvalid)
        begin
          n.lrd = 1'b1;
          n.laddr = `TF_DATA;
          n.pend = 1'b1;
          n.st = H_DWT;
        end
      end
      H_DWT:
      begin
        n.pend = 1'b0;
        if (!s.pend)
        begin
          n.word = link.rdata;
          n.wvalid = 1'b1;
          n.wcnt = s.wcnt + 8'h01;
          n.st = H_DATA;
          if (s.wcnt == `WORD_LAST)
          begin
            ev[`IRQ_BLOCK] = 1'b1;
            n.left = s.left - 16'h0001;
            n.st = H_WAIT;
            if (s.left == 16'h0001)
            begin
              ev[`IRQ_DONE] = 1'b1;
              n.st = H_IDLE;
            end
          end
        end
      end
      default:
      begin
        n.st = H_IDLE;
      end
    endcase
    // New events win over a clearing read in the same cycle.
    n.irq_st = n.irq_st | ev;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= H_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // =====================================================================
  // Outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata = s.rdata;
  assign irq = |(s.irq_st & s.irq_mask);
  assign link.wr = s.lwr;
  assign link.rd = s.lrd;
  assign link.addr = s.laddr;
  assign link.wdata = {8'h00, s.lwdata};

endmodule : log_reader_host

// ---- verif/rlx_checker.sv ----
`timescale 1ns/1ps
`include "rlx_map.svh"
module rlx_checker
#(
  parameter logic DEV_SELECT = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic intrq
);
  // ====================================================================
  // Shadow of the task file
  // Feature enables are not visible here, so only requests that are bad
  // whatever the enables say are predicted to abort.
  logic [15:0] cnt_q;
  logic [15:0] start_q;
  logic [7:0] log_q;
  logic dev_q;
  logic abort_q;
  logic intrq_q;
  logic [8:0] words_q;
  logic go;
  logic bad;
  assign go = wr && addr == `TF_CMD && dev_q == DEV_SELECT;
  assign bad = wdata[7:0] != `CMD_READ_LOG_EXT || cnt_q == 16'h0000 || log_q == `LOG_SELFTEST
    || log_q inside {8'h13, 8'h14, 8'h16, 8'h17}
    || (log_q == `LOG_DIR && {1'b0, cnt_q} + {1'b0, start_q} != 17'h00001);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      start_q <= 16'h0000;
      log_q <= 8'h00;
      dev_q <= 1'b0;
      abort_q <= 1'b0;
      intrq_q <= 1'b0;
      words_q <= 9'h000;
    end
    else
    begin
      if (wr && addr == `TF_COUNT)
        cnt_q <= {cnt_q[7:0], wdata[7:0]};
      if (wr && addr == `TF_CYLLOW)
        start_q <= {start_q[7:0], wdata[7:0]};
      if (wr && addr == `TF_SECNUM)
        log_q <= wdata[7:0];
      if (wr && addr == `TF_DEVHEAD)
        dev_q <= wdata[`DH_DEV_BIT];
      if (go)
        abort_q <= bad;
      intrq_q <= intrq;
      if (intrq && !intrq_q)
        words_q <= 9'h000;
      else if (rd && addr == `TF_DATA)
        words_q <= words_q + 9'h001;
    end
  end
  // ====================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_dh_fixed: assert property (wr && addr == `TF_DEVHEAD |-> wdata[7] && wdata[5])
    else $error("device/head written without its fixed bits");
  a_abort_irq: assert property (go && bad |-> ##[1:3] intrq)
    else $error("bad request raised no interrupt");
  a_abort_status: assert property (rd && addr == `TF_CMD && abort_q |=> rdata[7:0] == `ST_ABORT)
    else $error("aborted command shows wrong status");
  a_abort_error: assert property (rd && addr == `TF_ERROR && abort_q |=> rdata[7:0] == `ERR_ABRT)
    else $error("aborted command shows wrong error");
  // Status is only read after an interrupt, when the device is no longer busy.
  a_status_zero: assert property (rd && addr == `TF_CMD |=> (rdata[7:0] & 8'ha4) == 8'h00)
    else $error("status shows busy, fault or correction");
  a_error_zero: assert property (rd && addr == `TF_ERROR |=> (rdata[7:0] & 8'hab) == 8'h00)
    else $error("error register shows a fixed bit set");
  a_intrq_clear: assert property (intrq && rd && addr == `TF_CMD |=> !intrq)
    else $error("status read left interrupt pending");
  a_block_words: assert property (rd && addr == `TF_DATA |-> words_q < 9'd256)
    else $error("more than one sector read per interrupt");
  a_data_gap: assert property (rd && addr == `TF_DATA |=> (!(rd && addr == `TF_DATA)) [*2])
    else $error("data reads too close together");
  a_dir_block: assert property (go && !bad && log_q == `LOG_DIR |-> ##[1:3] intrq)
    else $error("directory read raised no block interrupt");
endmodule : rlx_checker

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "rlx_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  rlx_pkg::feat_type feat_en = 9'h1ff;
  logic [7:0] log_sel;
  logic [15:0] log_sector;
  logic [7:0] log_word;
  logic [15:0] log_data;
  logic busy;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] r;
  logic msk = 1'b1;
  // Requests as {log, count, start}.
  localparam logic [39:0] BAD [9] = '{40'h06_0001_0000, 40'h13_0001_0000, 40'h14_0001_0000, 40'h16_0001_0000,
    40'h17_0001_0000, 40'h00_0000_0000, 40'h00_0100_0000, 40'h00_0001_0100, 40'h80_0002_000f};
  localparam logic [7:0] FL [9] = '{8'h03, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h21, 8'h80, 8'h15};
  localparam logic [39:0] GOOD [13] = '{40'h00_0001_0000, 40'h03_0001_0000, 40'h07_0001_0000,
    40'h08_0001_0000, 40'h10_0001_0000, 40'h11_0001_0000, 40'h12_0001_0000, 40'h15_0001_0000,
    40'h21_0001_0000, 40'h22_0001_0000, 40'h30_0001_0000, 40'h80_0002_000e, 40'h9f_0001_000f};
  always #2.5 sys_clk = ~sys_clk;
  // The log store answers in the same cycle, so it is modelled combinationally.
  assign log_data = {log_sel ^ log_sector[7:0], log_word};
  ata_link_if link();
  log_reader_host u_log_reader_host (.sys_clk(sys_clk), .rst(rst), .link(link), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  log_reader_device #(.DEV_SELECT(1'b0)) u_log_reader_device (.sys_clk(sys_clk), .rst(rst), .link(link),
    .feat_en(feat_en), .log_sel(log_sel), .log_sector(log_sector), .log_word(log_word), .log_data(log_data),
    .busy(busy));
  rlx_checker #(.DEV_SELECT(1'b0)) u_rlx_checker (.sys_clk(sys_clk), .rst(rst), .wr(link.wr), .rd(link.rd),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .intrq(link.intrq));
  // ====================================================================
  // Bus tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic we, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~we;
    avs_write <= we;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    `CHK("waitrequest", 1'b0, avs_waitrequest)
  endtask : bus
  task automatic poll(input logic [2:0] a, input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    while (r[b] !== v && n < 3000);
    `CHK("poll", v, r[b])
  endtask : poll
  task automatic run_cmd(input logic [39:0] c, input logic ab);
    logic [15:0] s;
    bus(1'b1, `CR_XFER, {c[15:0], c[31:16]});
    bus(1'b1, `CR_CTRL, {15'h0, 1'b0, c[39:32], 7'h0, 1'b1});
    if (ab)
    begin
      poll(`CR_STATUS, 0, 1'b0);
      `CHK("abort codes", 16'h0451, r[23:8])
      repeat (2) @(posedge sys_clk);
      `CHK("irq", msk, irq)
      bus(1'b0, `CR_IRQ_ST, 32'h0);
      `CHK("abort flags", 3'b100, r[2:0] & 3'b101)
      @(posedge sys_clk);
      `CHK("irq cleared", 1'b0, irq)
    end
    else
    begin
      for (int b = 0; b < c[31:16]; b++)
        for (int w = 0; w < 256; w++)
        begin
          s = c[15:0] + b[15:0];
          poll(`CR_STATUS, 1, 1'b1);
          bus(1'b0, `CR_DATA, 32'h0);
          `CHK("log word", {c[39:32] ^ s[7:0], w[7:0]}, r[15:0])
        end
      poll(`CR_IRQ_ST, 1, 1'b1);
      `CHK("done flags", 3'b011, r[2:0])
    end
  endtask : run_cmd
  // ====================================================================
  // Tests
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 3'h6, 32'h0);
    `CHK("unmapped", 32'h0, r)
    bus(1'b1, `CR_IRQ_MASK, 32'h7);
    bus(1'b0, `CR_IRQ_MASK, 32'h0);
    `CHK("mask", 3'h7, r[2:0])
    for (int i = 0; i < 9; i++)
      run_cmd(BAD[i], 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      feat_en <= ~(9'h001 << i);
      run_cmd({FL[i], 32'h0001_0000}, 1'b1);
    end
    feat_en <= 9'h1ff;
    bus(1'b1, `CR_IRQ_MASK, 32'h0);
    msk = 1'b0;
    run_cmd(BAD[0], 1'b1);
    bus(1'b1, `CR_IRQ_MASK, 32'h7);
    msk = 1'b1;
    $display("test refused requests done");
    for (int i = 0; i < 13; i++)
      run_cmd(GOOD[i], 1'b0);
    $display("test log reads done");
    // A valid request, so a wrongly taken command would leave the device busy.
    bus(1'b1, `CR_XFER, 32'h0000_0001);
    bus(1'b1, `CR_CTRL, 32'h0001_0001);
    repeat (40) @(posedge sys_clk);
    `CHK("other device busy", 1'b0, busy)
    bus(1'b0, `CR_IRQ_ST, 32'h0);
    `CHK("other device flags", 3'b000, r[2:0])
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, `CR_STATUS, 32'h0);
    `CHK("status after reset", 32'h0, r)
    run_cmd(GOOD[0], 1'b0);
    $display("test device select and reset done");
    conclude();
  end
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    conclude();
  end
endmodule : tb
